/* shared/sbtc_pkg.sv */
// Purpose: constants shared by the sixteen-bit timer/counter design
// Assumes: 32-bit AXI4-Lite register window, one aligned word per register
// Notes: offsets are byte addresses inside the slave window
`default_nettype none
package sbtc_pkg;
  // ----
  // register map
  // ----
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_LOW = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ = 4'hC;
  // ----
  // field layout of timer_control
  // ----
  localparam int CTRL_W = 6;
  localparam int RUN_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam int BYP_BIT = 2;
  localparam int OSC_BIT = 3;
  localparam int PS_LSB = 4;
  localparam int PS_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  // ----
  // field layout of the flag/enable register
  // ----
  localparam int FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  // ----
  // count and bus values
  // ----
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PS_DIV1 = 2'b00,
    PS_DIV2 = 2'b01,
    PS_DIV4 = 2'b10,
    PS_DIV8 = 2'b11
  } sbtc_ps_e;
endpackage : sbtc_pkg
`default_nettype wire

/* rtl/sbtc_prescaler.sv */
// Purpose: input prescaler, divides count events by 1, 2, 4 or 8
// Assumes: events arrive as one-cycle pulses on clk_sys
// Notes: keeps dividing whatever the downstream stage does
`default_nettype none
module sbtc_prescaler
  import sbtc_pkg::*;
#(
  parameter int DIV_BITS = 3
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic eventIn, // one-cycle count event
  input wire sbtc_pkg::sbtc_ps_e ratioSel, // division ratio
  output logic eventOut // one pulse per ratio events
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DIV_BITS < 3) begin : g_chk
    $error("sbtc_prescaler needs DIV_BITS of at least 3");
  end

  logic [DIV_BITS-1:0] cnt_r;
  logic [DIV_BITS-1:0] last;

  always_comb begin
    unique case (ratioSel)
      PS_DIV1: last = DIV_BITS'(0);
      PS_DIV2: last = DIV_BITS'(1);
      PS_DIV4: last = DIV_BITS'(3);
      PS_DIV8: last = DIV_BITS'(7);
    endcase
  end

  // ----------------------------------------------------------------
  // ripple-equivalent divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (eventIn) begin
      if (cnt_r >= last) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + DIV_BITS'(1);
      end
    end
  end

  assign eventOut = eventIn && (cnt_r >= last);
endmodule : sbtc_prescaler
`default_nettype wire

/* rtl/sbtc_timer.sv */
// Overview of operation
// - sixteen-bit count from two bytes, counts up and wraps to zero
// - wrap sets sticky overflow flag; interrupt only while its enable is set
// - timer mode counts the instruction clock once per cycle
// - control bit 1 picks external rising edges or the internal clock
// - control bit 0 runs the counter; clear holds the value
// - control bits 5:4 pick prescale 1, 2, 4 or 8
// - control bit 3 enables the crystal amplifier, clear powers it down
// - bit 2 bypasses input synchronisation in external mode, ignored otherwise
// - counter mode uses oscillator input pin if oscillator on, else shared pin
// - prescaler divides the raw input; synchronising follows the prescaler
// - synchronised counter mode in sleep holds count, prescaler keeps dividing
// - oscillator enabled forces both oscillator pins to inputs
// - synchronised edges reach the count a few cycles later
// - control bits 7 and 6 read as zero
// - control bits clear at reset: stopped, timer mode, divide one, osc off
// - an internal reset input from the compare unit clears the count
// - compare reset clears the count without setting the overflow flag
// - a software write to a count byte wins over a simultaneous compare reset of that byte
//
// Purpose: sixteen-bit timer/counter with AXI4-Lite register access
// Assumes: clk_sys is the instruction clock (10 MHz); pins are asynchronous
// Notes: unmapped addresses answer SLVERR, reads of them return zero
//
// Local design decisions: the address map and register access over AXI4-Lite.
`default_nettype none
module sbtc_timer
  import sbtc_pkg::*;
(
  input wire logic clk_sys, // system clock, instruction rate
  input wire logic resetn, // asynchronous reset, active low
  input wire logic [sbtc_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // write protection, unused
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [sbtc_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // read protection, unused
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic extCountIn, // shared osc-output/external-count pin level
  input wire logic oscInPinIn, // oscillator input pin level
  input wire logic sleepMode, // core asleep, phase clocks stopped
  input wire logic cmpTrigger, // compare_unit special event, one cycle
  input wire logic portOscInDrive, // port_direction_control wants to drive osc in
  input wire logic portOscOutDrive, // port_direction_control wants to drive osc out
  input wire logic portOscInData, // port data for osc input pin
  input wire logic portOscOutData, // port data for osc output pin
  output logic oscInPinOut, // osc input pin drive value
  output logic oscInPinOe, // osc input pin output enable
  output logic oscOutPinOut, // osc output pin drive value
  output logic oscOutPinOe, // osc output pin output enable
  output logic crystalAmpEn, // crystal inverter and feedback enable
  output logic overflowIrq // overflow interrupt request, level
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_r;
  logic [7:0] countHigh_r;
  logic [7:0] countLow_r;
  logic overflowFlag_r;
  logic overflowIrqEnable_r;
  logic [2:0] extSync_r;
  logic [2:0] oscSync_r;
  logic extLevel_r;
  logic oscLevel_r;
  logic selLevelPrev_r;
  logic [1:0] phaseSample_r;
  logic syncTick_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awReady_r;
  logic wReady_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic arReady_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic irq_r;
  logic oscInOe_r;
  logic oscOutOe_r;
  logic oscInOut_r;
  logic oscOutOut_r;
  logic ampEn_r;

  // ----------------------------------------------------------------
  // control field views
  // ----------------------------------------------------------------
  logic countRun;
  logic countSourceSelect;
  logic syncBypass;
  logic crystalOscEnable;
  sbtc_ps_e prescaleSelect;

  assign countRun = ctrl_r[RUN_BIT];
  assign countSourceSelect = ctrl_r[SRC_BIT];
  assign syncBypass = ctrl_r[BYP_BIT];
  assign crystalOscEnable = ctrl_r[OSC_BIT];
  assign prescaleSelect = sbtc_ps_e'(ctrl_r[PS_LSB +: PS_W]);

  function automatic logic addrHit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    addrHit = (a == ofs);
  endfunction : addrHit

  function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
    addrMapped = addrHit(a, OFS_CTRL) || addrHit(a, OFS_HIGH) ||
                 addrHit(a, OFS_LOW) || addrHit(a, OFS_IRQ);
  endfunction : addrMapped

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, level moves when 2nd and 3rd agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      extSync_r <= 3'h0;
      oscSync_r <= 3'h0;
      extLevel_r <= 1'b0;
      oscLevel_r <= 1'b0;
    end else begin
      extSync_r <= {extSync_r[1:0], extCountIn};
      oscSync_r <= {oscSync_r[1:0], oscInPinIn};
      if (extSync_r[1] == extSync_r[2]) begin
        extLevel_r <= extSync_r[2];
      end
      if (oscSync_r[1] == oscSync_r[2]) begin
        oscLevel_r <= oscSync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // count source and prescaler input
  // ----------------------------------------------------------------
  logic selLevel;
  logic extEdge;
  logic prescaleIn;
  logic prescaleOut;

  assign selLevel = crystalOscEnable ? oscLevel_r : extLevel_r;
  assign extEdge = selLevel && !selLevelPrev_r;
  assign prescaleIn = countRun && (countSourceSelect ? extEdge : 1'b1);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      selLevelPrev_r <= 1'b0;
    end else begin
      selLevelPrev_r <= selLevel;
    end
  end

  // divider sits ahead of the synchroniser and ignores sleep
  sbtc_prescaler #(
    .DIV_BITS(3)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .eventIn(prescaleIn),
    .ratioSel(prescaleSelect),
    .eventOut(prescaleOut)
  );

  // ----------------------------------------------------------------
  // synchroniser after the prescaler: two phase samples, then a tick
  // ----------------------------------------------------------------
  logic syncMode;
  logic countTick;

  assign syncMode = countSourceSelect && !syncBypass;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phaseSample_r <= 2'h0;
      syncTick_r <= 1'b0;
    end else if (sleepMode) begin
      phaseSample_r <= 2'h0;
      syncTick_r <= 1'b0;
    end else begin
      phaseSample_r <= {phaseSample_r[0], prescaleOut && syncMode};
      syncTick_r <= phaseSample_r[1];
    end
  end

  always_comb begin
    if (!countSourceSelect) begin
      countTick = prescaleOut && !sleepMode;
    end else if (syncBypass) begin
      countTick = prescaleOut;
    end else begin
      countTick = syncTick_r && !sleepMode;
    end
  end

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic doWrite;
  logic wrCtrl;
  logic wrHigh;
  logic wrLow;
  logic wrIrq;

  assign doWrite = awHeld_r && wHeld_r && !bValid_r;
  assign wrCtrl = doWrite && wStrb_r[0] && addrHit(awAddr_r, OFS_CTRL);
  assign wrHigh = doWrite && wStrb_r[0] && addrHit(awAddr_r, OFS_HIGH);
  assign wrLow = doWrite && wStrb_r[0] && addrHit(awAddr_r, OFS_LOW);
  assign wrIrq = doWrite && wStrb_r[0] && addrHit(awAddr_r, OFS_IRQ);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      awReady_r <= 1'b0;
    end else if (s_axi_awvalid && awReady_r) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
      awReady_r <= 1'b0;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end else begin
      awReady_r <= !awHeld_r && !bValid_r;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wHeld_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      wReady_r <= 1'b0;
    end else if (s_axi_wvalid && wReady_r) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
      wReady_r <= 1'b0;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end else begin
      wReady_r <= !wHeld_r && !bValid_r;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      bResp_r <= addrMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bValid_r && s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_r <= wData_r[CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // counter: write, then compare reset, then increment
  // ----------------------------------------------------------------
  logic lowCarry;
  logic wrapEvent;

  assign lowCarry = countTick && (countLow_r == COUNT_MAX[7:0]);
  assign wrapEvent = countTick && ({countHigh_r, countLow_r} == COUNT_MAX) &&
                     !wrHigh && !wrLow && !cmpTrigger;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      countLow_r <= COUNT_RESET[7:0];
    end else if (wrLow) begin
      countLow_r <= wData_r[7:0];
    end else if (cmpTrigger) begin
      countLow_r <= BYTE_ZERO;
    end else if (countTick) begin
      countLow_r <= countLow_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      countHigh_r <= COUNT_RESET[15:8];
    end else if (wrHigh) begin
      countHigh_r <= wData_r[7:0];
    end else if (cmpTrigger) begin
      countHigh_r <= BYTE_ZERO;
    end else if (lowCarry) begin
      countHigh_r <= countHigh_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // overflow flag and interrupt; a wrap beats a same-cycle clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      overflowFlag_r <= 1'b0;
    end else if (wrapEvent) begin
      overflowFlag_r <= 1'b1;
    end else if (wrIrq && wData_r[FLAG_BIT]) begin
      overflowFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      overflowIrqEnable_r <= 1'b0;
    end else if (wrIrq) begin
      overflowIrqEnable_r <= wData_r[IRQ_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= overflowFlag_r && overflowIrqEnable_r;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic [31:0] readMux;

  always_comb begin
    readMux = 32'h0000_0000;
    if (addrHit(s_axi_araddr, OFS_CTRL)) begin
      readMux[CTRL_W-1:0] = ctrl_r;
    end else if (addrHit(s_axi_araddr, OFS_HIGH)) begin
      readMux[7:0] = countHigh_r;
    end else if (addrHit(s_axi_araddr, OFS_LOW)) begin
      readMux[7:0] = countLow_r;
    end else if (addrHit(s_axi_araddr, OFS_IRQ)) begin
      readMux[FLAG_BIT] = overflowFlag_r;
      readMux[IRQ_EN_BIT] = overflowIrqEnable_r;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && arReady_r) begin
      arReady_r <= 1'b0;
      rValid_r <= 1'b1;
      rData_r <= readMux;
      rResp_r <= addrMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end else begin
      arReady_r <= !rValid_r;
    end
  end

  // ----------------------------------------------------------------
  // oscillator pins and amplifier
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      oscInOe_r <= 1'b0;
      oscOutOe_r <= 1'b0;
      oscInOut_r <= 1'b0;
      oscOutOut_r <= 1'b0;
      ampEn_r <= 1'b0;
    end else begin
      oscInOe_r <= portOscInDrive && !crystalOscEnable;
      oscOutOe_r <= portOscOutDrive && !crystalOscEnable;
      oscInOut_r <= portOscInData;
      oscOutOut_r <= portOscOutData;
      ampEn_r <= crystalOscEnable;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign oscInPinOe = oscInOe_r;
  assign oscOutPinOe = oscOutOe_r;
  assign oscInPinOut = oscInOut_r;
  assign oscOutPinOut = oscOutOut_r;
  assign crystalAmpEn = ampEn_r;
  assign overflowIrq = irq_r;
endmodule : sbtc_timer
`default_nettype wire

/* tb/sbtc_timer_monitor.sv */
// Purpose: port-level checks for the sixteen-bit timer/counter
// Assumes: bound into sbtc_timer, one clock domain
// Notes: read data is judged at the edge after the read handshake
`default_nettype none
module sbtc_timer_monitor
  import sbtc_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [sbtc_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_awready, // write address ready
  input wire logic s_axi_wready, // write data ready
  input wire logic s_axi_bvalid, // write response valid
  input wire logic portOscInDrive, // port wants to drive osc in
  input wire logic oscInPinOe, // osc input pin enable
  input wire logic oscOutPinOe, // osc output pin enable
  input wire logic crystalAmpEn, // crystal amplifier enable
  input wire logic overflowIrq // overflow request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ----
  // properties
  // ----
  property p_osc_inputs; crystalAmpEn |-> !oscInPinOe && !oscOutPinOe; endproperty
  a_osc_inputs: assert property (p_osc_inputs) else $error("osc pin driven");
  property p_in_oe;
    $past(resetn) |-> oscInPinOe == ($past(portOscInDrive) && !crystalAmpEn);
  endproperty
  a_in_oe: assert property (p_in_oe) else $error("osc in enable wrong");
  sequence s_rd; $rose(s_axi_rvalid); endsequence
  property p_ctrl_rd; s_rd ##0 $past(s_axi_araddr) == OFS_CTRL |-> s_axi_rdata[31:6] == 26'h0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control top bits set");
  property p_byte_rd;
    s_rd ##0 ($past(s_axi_araddr) == OFS_HIGH || $past(s_axi_araddr) == OFS_LOW)
      |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_byte_rd: assert property (p_byte_rd) else $error("count byte too wide");
  property p_rst_amp; $rose(resetn) |-> !crystalAmpEn [*2]; endproperty
  a_rst_amp: assert property (p_rst_amp) else $error("amp on after reset");
  property p_irq_idle; $rose(resetn) |-> !overflowIrq [*3]; endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq with enable clear");
  property p_amp_moves; $changed(crystalAmpEn) |-> $past(s_axi_bvalid); endproperty
  a_amp_moves: assert property (p_amp_moves) else $error("amp moved unwritten");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read accepted early");
  property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_block: assert property (p_w_block) else $error("write accepted early");
  property p_slverr;
    s_rd ##0 ($past(s_axi_araddr) & 4'h3) != 4'h0 |-> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == 32'h0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read answered");
  c_irq: cover property ($rose(overflowIrq));
  c_amp: cover property ($rose(crystalAmpEn));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : sbtc_timer_monitor
`default_nettype wire

/* tb/sbtc_ext_src.sv */
// Purpose: external count source on the timer's two count pins
// Assumes: pulse widths are given in clk_sys cycles
// Notes: both pins rest low (pull-down) between bursts
`default_nettype none
module sbtc_ext_src (
  input wire logic clk_sys, // system clock
  output logic extPin, // shared external count pin
  output logic oscPin // oscillator input pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    extPin = 1'h0;
    oscPin = 1'h0;
  end
  // each level lasts at least the given cycles, well above the sampling need
  task automatic burst(input int n, input int hi, input int lo, input bit osc);
    repeat (n) begin
      @(posedge clk_sys);
      if (osc) oscPin <= 1'h1;
      else extPin <= 1'h1;
      repeat (hi) @(posedge clk_sys);
      oscPin <= 1'h0;
      extPin <= 1'h0;
      repeat (lo) @(posedge clk_sys);
    end
  endtask : burst
endmodule : sbtc_ext_src
`default_nettype wire

/* tb/sbtc_timer_tb.sv */
// Purpose: self-checking bench for the sixteen-bit timer/counter
// Assumes: 10 MHz clk_sys, AXI4-Lite master tasks below
// Notes: counts are read back once count events stop; only the wrap test stops the timer first
`default_nettype none
module sbtc_timer_tb
  import sbtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0;
  logic sleepMode = 1'h0, cmpTrigger = 1'h0, portOscInDrive = 1'h0, portOscInData = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic extCountIn, oscInPinIn, oscInPinOut, oscInPinOe, oscOutPinOut, oscOutPinOe;
  logic crystalAmpEn, overflowIrq;
  int fail_count = 0;
  int total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  sbtc_timer i_dut (
    .clk_sys, .resetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .extCountIn,
    .oscInPinIn, .sleepMode, .cmpTrigger, .portOscInDrive, .portOscOutDrive(portOscInDrive),
    .portOscInData, .portOscOutData(portOscInData), .oscInPinOut, .oscInPinOe, .oscOutPinOut,
    .oscOutPinOe, .crystalAmpEn, .overflowIrq
  );
  sbtc_ext_src i_src (.clk_sys, .extPin(extCountIn), .oscPin(oscInPinIn));
  // ----
  // bus and check tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    chk(nm, rd, exp);
  endtask : rchk
  task automatic rst();
    resetn <= 1'h0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
  endtask : rst
  task automatic conclude();
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rchk("control", OFS_CTRL, 32'h0);
    rchk("count low", OFS_LOW, 32'h0);
    wr(OFS_CTRL, 32'hFFFF_FFC0);
    rchk("control top", OFS_CTRL, 32'h0);
    rchk("unmapped", 4'h2, 32'h0);
    chk("unmapped rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(4'h6, 32'h1);
    chk("unmapped bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
  endtask : t_reset
  task automatic t_wrap();
    logic [31:0] v;
    wr(OFS_IRQ, 32'h3);
    wr(OFS_HIGH, 32'hFF);
    wr(OFS_LOW, 32'hF0);
    wr(OFS_CTRL, 32'h1);
    repeat (30) @(posedge clk_sys);
    wr(OFS_CTRL, 32'h0);
    rchk("high after wrap", OFS_HIGH, 32'h0);
    rchk("low after wrap", OFS_LOW, 32'h12);
    v = rd;
    chk("timer span", 32'(v >= 32'h10 && v <= 32'h14), 32'h1);
    repeat (5) @(posedge clk_sys);
    rchk("held count", OFS_LOW, v);
    rchk("flag", OFS_IRQ, 32'h3);
    chk("irq", {31'h0, overflowIrq}, 32'h1);
    wr(OFS_IRQ, 32'h0);
    rchk("sticky flag", OFS_IRQ, 32'h1);
    chk("masked irq", {31'h0, overflowIrq}, 32'h0);
    wr(OFS_IRQ, 32'h1);
    rchk("cleared flag", OFS_IRQ, 32'h0);
  endtask : t_wrap
  task automatic t_prescale();
    logic [31:0] c;
    portOscInDrive <= 1'h1;
    portOscInData <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      c = 32'h3 | (i < 4 ? i << 4 : 0) | (i == 4 ? 32'h4 : 0) | (i == 5 ? 32'h8 : 0);
      wr(OFS_CTRL, c & 32'h3E);
      wr(OFS_LOW, 32'h0);
      wr(OFS_CTRL, c);
      @(posedge clk_sys);
      chk("amp enable", {31'h0, crystalAmpEn}, {31'h0, c[3]});
      chk("osc drive", 32'({oscInPinOe, oscOutPinOe}), 32'({2{!c[3]}}));
      i_src.burst(8, i == 4 ? 12 : 5, 5, c[3]);
      repeat (8) @(posedge clk_sys);
      rchk("prescaled count", OFS_LOW, 32'h8 >> (i < 4 ? i : 0));
    end
    chk("osc data", 32'({oscInPinOut, oscOutPinOut}), 32'h3);
  endtask : t_prescale
  task automatic t_sleep();
    wr(OFS_CTRL, 32'h12);
    wr(OFS_LOW, 32'h0);
    wr(OFS_CTRL, 32'h13);
    sleepMode <= 1'h1;
    i_src.burst(3, 5, 5, 1'h0);
    repeat (8) @(posedge clk_sys);
    rchk("asleep count", OFS_LOW, 32'h0);
    sleepMode <= 1'h0;
    i_src.burst(1, 5, 5, 1'h0);
    repeat (8) @(posedge clk_sys);
    rchk("woken count", OFS_LOW, 32'h1);
  endtask : t_sleep
  task automatic cmp_pulse(input int n);
    repeat (n) @(posedge clk_sys);
    cmpTrigger <= 1'h1;
    @(posedge clk_sys);
    cmpTrigger <= 1'h0;
  endtask : cmp_pulse
  task automatic t_cmp();
    wr(OFS_CTRL, 32'h3);
    wr(OFS_HIGH, 32'hFF);
    wr(OFS_LOW, 32'hFF);
    // trigger lands on the edge where the synchronised pin edge would wrap
    fork
      i_src.burst(1, 5, 5, 1'h0);
      cmp_pulse(8);
    join
    rchk("cleared low", OFS_LOW, 32'h0);
    rchk("no wrap flag", OFS_IRQ, 32'h0);
    wr(OFS_HIGH, 32'h12);
    fork
      wr(OFS_LOW, 32'h5A);
      cmp_pulse(2);
    join
    rchk("write wins", OFS_LOW, 32'h5A);
    rchk("high cleared", OFS_HIGH, 32'h0);
  endtask : t_cmp
  initial begin
    rst();
    t_reset();
    t_wrap();
    rst();
    t_prescale();
    t_sleep();
    t_cmp();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    conclude();
  end
endmodule : sbtc_timer_tb
bind sbtc_timer sbtc_timer_monitor i_mon (
  .clk_sys, .resetn, .s_axi_araddr, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .portOscInDrive, .oscInPinOe, .oscOutPinOe,
  .crystalAmpEn, .overflowIrq
);
`default_nettype wire
